// ### ddsc_pkg.sv
// package for the sync and datapath control bank
// assumes a byte-wide register port on the divided sample clock
`default_nettype none
package ddsc_pkg;
    localparam logic [7:0] ADDR_SYNC_GATE = 8'h3A;
    localparam logic [7:0] ADDR_OFFSET_CTL = 8'h40;
    localparam logic [7:0] ADDR_FLAG_CTL = 8'h45;
    localparam logic [7:0] ADDR_UP_LO = 8'h47;
    localparam logic [7:0] ADDR_UP_HI = 8'h48;
    localparam logic [7:0] ADDR_LO_LO = 8'h49;
    localparam logic [7:0] ADDR_LO_HI = 8'h4A;
    localparam logic [7:0] ADDR_HOLD_LO = 8'h4B;
    localparam logic [7:0] ADDR_HOLD_HI = 8'h4C;
    localparam logic [7:0] ADDR_FILT = 8'h50;
    localparam logic [7:0] ADDR_OSC = 8'h51;
    localparam logic [7:0] ADDR_TW3 = 8'h52;
    localparam logic [7:0] ADDR_TW2 = 8'h53;
    localparam logic [7:0] ADDR_TW1 = 8'h54;
    localparam logic [7:0] ADDR_TW0 = 8'h55;
    localparam logic [7:0] ADDR_PH1 = 8'h56;
    localparam logic [7:0] ADDR_PH0 = 8'h57;
    localparam logic [7:0] ADDR_DP_SYNC = 8'h58;
    // field positions and bandwidth code limit
    localparam int SG_MASTER = 0;
    localparam int SG_DIV_EN = 1;
    localparam int SG_DIV_ONE = 2;
    localparam int OC_ENABLE = 1;
    localparam int OC_BW_LSB = 2;
    localparam int OC_FREEZE = 6;
    localparam int FC_DETECT = 0;
    localparam int FC_FVAL = 2;
    localparam int FC_FORCE = 3;
    localparam int FG_FIR_MODE = 4;
    localparam int FG_OUT_GAIN = 3;
    localparam int FG_NARROW = 2;
    localparam int OS_PH_DITH = 1;
    localparam int OS_AMP_DITH = 2;
    localparam int OS_REVERSE = 5;
    localparam int OS_QSYNC = 6;
    localparam int DS_TUN_EN = 0;
    localparam int DS_TUN_ONE = 1;
    localparam int DS_FIR_EN = 4;
    localparam int DS_FIR_ONE = 5;
    localparam int DS_QTR_EN = 6;
    localparam int DS_QTR_ONE = 7;
    localparam logic [3:0] BW_MAX = 4'hD;
    // reset values, read-as-one masks and magnitude width
    localparam logic [7:0] RST_FILT = 8'hB0;
    localparam logic [7:0] RST_OSC = 8'h51;
    localparam logic [7:0] RST_TW3 = 8'h40;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] FILT_ONES = 8'hA0;
    localparam logic [7:0] OSC_ONES = 8'h11;
    localparam int MAG_W = 13;

    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ddsc_req_type;

    typedef struct packed {
        logic div_sync;
        logic qtr_sync;
        logic fir_sync;
        logic tun_sync;
    } ddsc_sync_type;

    typedef struct packed {
        logic offset_en;
        logic offset_freeze;
        logic [3:0] offset_bw;
        logic fir_low_latency;
        logic out_gain_6db;
        logic narrow_mode;
        logic [1:0] dp_gain;
        logic reverse;
        logic amp_dither;
        logic phase_dither;
        logic qtr_link;
        logic [31:0] tuning_word;
        logic [15:0] phase_start_value;
    } ddsc_cfg_type;
endpackage
`default_nettype wire

// ### ddsc_bank.sv
// register bank: sync gating, offset removal, level flag, datapath cfg
// assumes the register port and magnitude come from this clock domain;
// the sync pulse arrives already conditioned but asynchronous
//
// Notes on behaviour
// RQ1 - no sync passes unless master enable set
// RQ2 - divider gets every pulse while its and master enables high
// RQ3 - divider one-shot: first pulse only, enable self-clears
// RQ4 - freeze bit stops dc estimate updates, last value kept
// RQ5 - 4-bit averaging bandwidth code, codes 14 and 15 act as 13
// RQ6 - offset enable sums dc estimate into sample path
// RQ7 - force enable drives flag pin with force value bit
// RQ8 - comparator drives flag pin only when detect enable set
// RQ9 - flag sets when magnitude exceeds 13-bit upper threshold
// RQ10 - flag clears after dwell count samples below lower threshold
// RQ11 - dwell is 16 bits in divided sample clocks, two bytes
// RQ12 - filter mode bit selects high-performance or low-latency FIR
// RQ13 - output gain bit selects -6 dB or 0 dB
// RQ14 - narrow mode bypasses oscillators and filters, nine bits on top
// RQ15 - 2-bit datapath gain code 0, -6, -12, -18 dB
// RQ16 - reserved bits 7,5 of filter reg and 4,0 of osc reg read 1
// RQ17 - spectral reversal bit inverts output spectrum
// RQ18 - bit 2 enables amplitude dither, bit 1 phase dither
// RQ19 - quarter-rate link set by software only in fixed mode
// RQ20 - 32-bit tuning word, most significant byte lowest address
// RQ21 - phase start value loaded on oscillator start or sync
// RQ22 - quarter-rate oscillator sync, one-shot clears its enable
// RQ23 - FIR one-shot: first pulse only, enable clears
// RQ24 - FIR resyncs on every pulse while FIR and master enabled
// RQ25 - tunable oscillator reloads phase start value on each sync
// RQ26 - tunable one-shot: first pulse only, enable clears
// RQ27 - flag held between upper trigger and dwell-qualified clear
`default_nettype none
module ddsc_bank #(
    parameter int DWELL_W = 16
) (
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    input wire ddsc_pkg::ddsc_req_type REQ_I,
    input wire logic SYNC_I,
    input wire logic OSC_START_I,
    input wire logic [ddsc_pkg::MAG_W-1:0] MAG_I,
    input wire logic MAG_VALID_I,
    output logic [7:0] RDATA_O,
    output logic RVALID_O,
    output ddsc_pkg::ddsc_sync_type SYNC_O,
    output logic PHASE_LOAD_O,
    output ddsc_pkg::ddsc_cfg_type CFG_O,
    output logic LEVEL_FLAG_PIN_O
);
    if (DWELL_W != 16) begin : g_dwell_chk
        $error("dwell counter must be 16 bits");
    end

    ////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0] sync_gate_q, sync_gate_d;
    logic [7:0] offset_ctl_q, offset_ctl_d;
    logic [7:0] flag_ctl_q, flag_ctl_d;
    logic [7:0] up_lo_q, up_lo_d, up_hi_q, up_hi_d;
    logic [7:0] lo_lo_q, lo_lo_d, lo_hi_q, lo_hi_d;
    logic [7:0] hold_lo_q, hold_lo_d, hold_hi_q, hold_hi_d;
    logic [7:0] filt_q, filt_d, osc_q, osc_d;
    logic [31:0] tw_q, tw_d;
    logic [15:0] ph_q, ph_d;
    logic [7:0] dp_sync_q, dp_sync_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    // sync input synchroniser and rising-edge pulse
    logic sync_m_q, sync_s_q, sync_p_q;
    logic sync_pulse;
    logic div_fire, qtr_fire, fir_fire, tun_fire;
    ddsc_pkg::ddsc_sync_type sync_out_q, sync_out_d;
    logic phase_load_q, phase_load_d;

    function automatic logic wr(input ddsc_pkg::ddsc_req_type r,
                                input logic [7:0] a);
        wr = r.we && (r.addr == a);
    endfunction

    function automatic logic [12:0] thr(input logic [7:0] hi,
                                        input logic [7:0] lo);
        thr = {hi[4:0], lo};
    endfunction

    always_ff @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            sync_m_q <= 1'b0;
            sync_s_q <= 1'b0;
            sync_p_q <= 1'b0;
        end else begin
            sync_m_q <= SYNC_I;
            sync_s_q <= sync_m_q;
            sync_p_q <= sync_s_q;
        end
    end

    assign sync_pulse = sync_s_q && !sync_p_q;

    ////////////////////////////////////////////////////////////////////
    // sync gating
    always_comb begin
        div_fire = sync_pulse && sync_gate_q[ddsc_pkg::SG_MASTER]
                   && sync_gate_q[ddsc_pkg::SG_DIV_EN];  // [RQ1] [RQ2]
        qtr_fire = sync_pulse && sync_gate_q[ddsc_pkg::SG_MASTER]
                   && dp_sync_q[ddsc_pkg::DS_QTR_EN];  // [RQ1] [RQ22]
        fir_fire = sync_pulse && sync_gate_q[ddsc_pkg::SG_MASTER]
                   && dp_sync_q[ddsc_pkg::DS_FIR_EN];  // [RQ1] [RQ24]
        tun_fire = sync_pulse && sync_gate_q[ddsc_pkg::SG_MASTER]
                   && dp_sync_q[ddsc_pkg::DS_TUN_EN];  // [RQ1] [RQ25]
        sync_out_d = {div_fire, qtr_fire, fir_fire, tun_fire};
        phase_load_d = tun_fire || OSC_START_I;  // [RQ21] [RQ25]
    end

    ////////////////////////////////////////////////////////////////////
    // register writes, then one-shot self-clears
    always_comb begin
        sync_gate_d = sync_gate_q;
        offset_ctl_d = offset_ctl_q;
        flag_ctl_d = flag_ctl_q;
        up_lo_d = up_lo_q;
        up_hi_d = up_hi_q;
        lo_lo_d = lo_lo_q;
        lo_hi_d = lo_hi_q;
        hold_lo_d = hold_lo_q;
        hold_hi_d = hold_hi_q;
        filt_d = filt_q;
        osc_d = osc_q;
        tw_d = tw_q;
        ph_d = ph_q;
        dp_sync_d = dp_sync_q;
        if (wr(REQ_I, ddsc_pkg::ADDR_SYNC_GATE)) begin
            sync_gate_d = {5'h0, REQ_I.wdata[2:0]};
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_OFFSET_CTL)) begin
            offset_ctl_d = {1'b0, REQ_I.wdata[6:1], 1'b0};
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_FLAG_CTL)) begin
            flag_ctl_d = {4'h0, REQ_I.wdata[3:2], 1'b0, REQ_I.wdata[0]};
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_UP_LO)) begin
            up_lo_d = REQ_I.wdata;
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_UP_HI)) begin
            up_hi_d = {3'h0, REQ_I.wdata[4:0]};
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_LO_LO)) begin
            lo_lo_d = REQ_I.wdata;
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_LO_HI)) begin
            lo_hi_d = {3'h0, REQ_I.wdata[4:0]};
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_HOLD_LO)) begin
            hold_lo_d = REQ_I.wdata;  // [RQ11]
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_HOLD_HI)) begin
            hold_hi_d = REQ_I.wdata;  // [RQ11]
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_FILT)) begin
            filt_d = {1'b1, REQ_I.wdata[6], 1'b1, REQ_I.wdata[4:0]};
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_OSC)) begin
            osc_d = {1'b0, REQ_I.wdata[6:5], 1'b1, REQ_I.wdata[3:1], 1'b1};
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_TW3)) begin
            tw_d[31:24] = REQ_I.wdata;  // [RQ20]
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_TW2)) begin
            tw_d[23:16] = REQ_I.wdata;
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_TW1)) begin
            tw_d[15:8] = REQ_I.wdata;
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_TW0)) begin
            tw_d[7:0] = REQ_I.wdata;  // [RQ20]
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_PH1)) begin
            ph_d[15:8] = REQ_I.wdata;  // [RQ21]
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_PH0)) begin
            ph_d[7:0] = REQ_I.wdata;
        end
        if (wr(REQ_I, ddsc_pkg::ADDR_DP_SYNC)) begin
            dp_sync_d = {REQ_I.wdata[7:4], 2'b00, REQ_I.wdata[1:0]};
        end
        // hardware event wins over a write
        if (div_fire && sync_gate_q[ddsc_pkg::SG_DIV_ONE]) begin
            sync_gate_d[ddsc_pkg::SG_DIV_EN] = 1'b0;  // [RQ3]
        end
        if (qtr_fire && dp_sync_q[ddsc_pkg::DS_QTR_ONE]) begin
            dp_sync_d[ddsc_pkg::DS_QTR_EN] = 1'b0;  // [RQ22]
        end
        if (fir_fire && dp_sync_q[ddsc_pkg::DS_FIR_ONE]) begin
            dp_sync_d[ddsc_pkg::DS_FIR_EN] = 1'b0;  // [RQ23]
        end
        if (tun_fire && dp_sync_q[ddsc_pkg::DS_TUN_ONE]) begin
            dp_sync_d[ddsc_pkg::DS_TUN_EN] = 1'b0;  // [RQ26]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        rvalid_d = REQ_I.re;
        rdata_d = rdata_q;
        if (REQ_I.re) begin
            unique case (REQ_I.addr)
                ddsc_pkg::ADDR_SYNC_GATE: rdata_d = sync_gate_q;
                ddsc_pkg::ADDR_OFFSET_CTL: rdata_d = offset_ctl_q;
                ddsc_pkg::ADDR_FLAG_CTL: rdata_d = flag_ctl_q;
                ddsc_pkg::ADDR_UP_LO: rdata_d = up_lo_q;
                ddsc_pkg::ADDR_UP_HI: rdata_d = up_hi_q;
                ddsc_pkg::ADDR_LO_LO: rdata_d = lo_lo_q;
                ddsc_pkg::ADDR_LO_HI: rdata_d = lo_hi_q;
                ddsc_pkg::ADDR_HOLD_LO: rdata_d = hold_lo_q;
                ddsc_pkg::ADDR_HOLD_HI: rdata_d = hold_hi_q;
                ddsc_pkg::ADDR_FILT:
                    rdata_d = filt_q | ddsc_pkg::FILT_ONES;  // [RQ16]
                ddsc_pkg::ADDR_OSC:
                    rdata_d = osc_q | ddsc_pkg::OSC_ONES;  // [RQ16]
                ddsc_pkg::ADDR_TW3: rdata_d = tw_q[31:24];
                ddsc_pkg::ADDR_TW2: rdata_d = tw_q[23:16];
                ddsc_pkg::ADDR_TW1: rdata_d = tw_q[15:8];
                ddsc_pkg::ADDR_TW0: rdata_d = tw_q[7:0];
                ddsc_pkg::ADDR_PH1: rdata_d = ph_q[15:8];
                ddsc_pkg::ADDR_PH0: rdata_d = ph_q[7:0];
                ddsc_pkg::ADDR_DP_SYNC: rdata_d = dp_sync_q;
                default: rdata_d = ddsc_pkg::RST_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration outputs
    ddsc_pkg::ddsc_cfg_type cfg_q, cfg_d;
    always_comb begin
        cfg_d.offset_en = offset_ctl_q[ddsc_pkg::OC_ENABLE];  // [RQ6]
        cfg_d.offset_freeze = offset_ctl_q[ddsc_pkg::OC_FREEZE];  // [RQ4]
        cfg_d.offset_bw = offset_ctl_q[5:2];
        if (offset_ctl_q[5:2] > ddsc_pkg::BW_MAX) begin
            cfg_d.offset_bw = ddsc_pkg::BW_MAX;  // [RQ5]
        end
        cfg_d.fir_low_latency = filt_q[ddsc_pkg::FG_FIR_MODE];  // [RQ12]
        cfg_d.out_gain_6db = filt_q[ddsc_pkg::FG_OUT_GAIN];  // [RQ13]
        cfg_d.narrow_mode = filt_q[ddsc_pkg::FG_NARROW];  // [RQ14]
        cfg_d.dp_gain = filt_q[1:0];  // [RQ15]
        cfg_d.reverse = osc_q[ddsc_pkg::OS_REVERSE];  // [RQ17]
        cfg_d.amp_dither = osc_q[ddsc_pkg::OS_AMP_DITH];  // [RQ18]
        cfg_d.phase_dither = osc_q[ddsc_pkg::OS_PH_DITH];  // [RQ18]
        cfg_d.qtr_link = osc_q[ddsc_pkg::OS_QSYNC];
        cfg_d.tuning_word = tw_q;  // [RQ20]
        cfg_d.phase_start_value = ph_q;  // [RQ21]
    end

    ////////////////////////////////////////////////////////////////////
    // level flag with dwell hysteresis
    logic flag_q, flag_d;
    logic [DWELL_W-1:0] dwell_q, dwell_d;
    logic pin_q, pin_d;
    always_comb begin
        flag_d = flag_q;
        dwell_d = dwell_q;
        if (!flag_ctl_q[ddsc_pkg::FC_DETECT]) begin
            flag_d = 1'b0;
            dwell_d = '0;
        end else if (MAG_VALID_I) begin
            if (MAG_I > thr(up_hi_q, up_lo_q)) begin
                flag_d = 1'b1;  // [RQ9]
                dwell_d = '0;
            end else if (flag_q && MAG_I < thr(lo_hi_q, lo_lo_q)) begin
                // count samples below, clear on reaching dwell [RQ10]
                if (dwell_q + 16'h0001 >= {hold_hi_q, hold_lo_q}) begin
                    flag_d = 1'b0;
                    dwell_d = '0;
                end else begin
                    dwell_d = dwell_q + 16'h0001;  // [RQ11]
                end
            end else begin
                dwell_d = '0;  // [RQ27]
            end
        end
        if (flag_ctl_q[ddsc_pkg::FC_FORCE]) begin
            pin_d = flag_ctl_q[ddsc_pkg::FC_FVAL];  // [RQ7]
        end else begin
            pin_d = flag_q && flag_ctl_q[ddsc_pkg::FC_DETECT];  // [RQ8]
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            sync_gate_q <= ddsc_pkg::RST_ZERO;
            offset_ctl_q <= ddsc_pkg::RST_ZERO;
            flag_ctl_q <= ddsc_pkg::RST_ZERO;
            up_lo_q <= ddsc_pkg::RST_ZERO;
            up_hi_q <= ddsc_pkg::RST_ZERO;
            lo_lo_q <= ddsc_pkg::RST_ZERO;
            lo_hi_q <= ddsc_pkg::RST_ZERO;
            hold_lo_q <= ddsc_pkg::RST_ZERO;
            hold_hi_q <= ddsc_pkg::RST_ZERO;
            filt_q <= ddsc_pkg::RST_FILT;
            osc_q <= ddsc_pkg::RST_OSC;
            tw_q <= {ddsc_pkg::RST_TW3, 24'h00_0000};
            ph_q <= 16'h0000;
            dp_sync_q <= ddsc_pkg::RST_ZERO;
            rdata_q <= ddsc_pkg::RST_ZERO;
            rvalid_q <= 1'b0;
            sync_out_q <= '0;
            phase_load_q <= 1'b0;
            cfg_q <= '0;
            flag_q <= 1'b0;
            dwell_q <= '0;
            pin_q <= 1'b0;
        end else begin
            sync_gate_q <= sync_gate_d;
            offset_ctl_q <= offset_ctl_d;
            flag_ctl_q <= flag_ctl_d;
            up_lo_q <= up_lo_d;
            up_hi_q <= up_hi_d;
            lo_lo_q <= lo_lo_d;
            lo_hi_q <= lo_hi_d;
            hold_lo_q <= hold_lo_d;
            hold_hi_q <= hold_hi_d;
            filt_q <= filt_d;
            osc_q <= osc_d;
            tw_q <= tw_d;
            ph_q <= ph_d;
            dp_sync_q <= dp_sync_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            sync_out_q <= sync_out_d;
            phase_load_q <= phase_load_d;
            cfg_q <= cfg_d;
            flag_q <= flag_d;
            dwell_q <= dwell_d;
            pin_q <= pin_d;
        end
    end

    assign RDATA_O = rdata_q;
    assign RVALID_O = rvalid_q;
    assign SYNC_O = sync_out_q;
    assign PHASE_LOAD_O = phase_load_q;
    assign CFG_O = cfg_q;
    assign LEVEL_FLAG_PIN_O = pin_q;
endmodule
`default_nettype wire

// ### ddsc_props.sv
// checker: port properties of the control bank
// assumes binding into ddsc_bank, sees only its ports
`default_nettype none
module ddsc_props (
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    input wire ddsc_pkg::ddsc_req_type REQ_I,
    input wire logic SYNC_I,
    input wire logic OSC_START_I,
    input wire logic [ddsc_pkg::MAG_W-1:0] MAG_I,
    input wire logic MAG_VALID_I,
    input wire logic [7:0] RDATA_O,
    input wire logic RVALID_O,
    input wire ddsc_pkg::ddsc_sync_type SYNC_O,
    input wire logic PHASE_LOAD_O,
    input wire ddsc_pkg::ddsc_cfg_type CFG_O,
    input wire logic LEVEL_FLAG_PIN_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!NRST_I);
    ////////////////////////////////////////
    // register shadow
    logic master_q, master_d, fw;
    logic [7:0] fc_q, fc_d;
    logic [12:0] up_q, up_d, lo_q, lo_d;
    assign fw = REQ_I.we && REQ_I.addr == ddsc_pkg::ADDR_FILT;
    always_comb begin
        master_d = master_q;
        fc_d = fc_q;
        up_d = up_q;
        lo_d = lo_q;
        if (REQ_I.we) begin
            case (REQ_I.addr)
                ddsc_pkg::ADDR_SYNC_GATE: master_d = REQ_I.wdata[0];
                ddsc_pkg::ADDR_FLAG_CTL: fc_d = REQ_I.wdata;
                ddsc_pkg::ADDR_UP_LO: up_d[7:0] = REQ_I.wdata;
                ddsc_pkg::ADDR_UP_HI: up_d[12:8] = REQ_I.wdata[4:0];
                ddsc_pkg::ADDR_LO_LO: lo_d[7:0] = REQ_I.wdata;
                ddsc_pkg::ADDR_LO_HI: lo_d[12:8] = REQ_I.wdata[4:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge CORE_CLK_I) begin
        if (!NRST_I) begin
            master_q <= 1'b0;
            fc_q <= 8'h00;
            up_q <= 13'h0000;
            lo_q <= 13'h0000;
        end else begin
            master_q <= master_d;
            fc_q <= fc_d;
            up_q <= up_d;
            lo_q <= lo_d;
        end
    end
    ////////////////////////////////////////
    property p_rd_ans;
        REQ_I.re |=> RVALID_O;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("no rvalid");
    property p_filt_ones;
        REQ_I.re && REQ_I.addr == ddsc_pkg::ADDR_FILT
            |=> RDATA_O[7] && RDATA_O[5];
    endproperty
    a_filt_ones: assert property (p_filt_ones) else $error("filt ones");
    property p_osc_ones;
        REQ_I.re && REQ_I.addr == ddsc_pkg::ADDR_OSC
            |=> RDATA_O[4] && RDATA_O[0];
    endproperty
    a_osc_ones: assert property (p_osc_ones) else $error("osc ones");
    property p_filt_cfg;
        fw ##1 !fw |=> {CFG_O.fir_low_latency, CFG_O.out_gain_6db,
            CFG_O.narrow_mode, CFG_O.dp_gain} == $past(REQ_I.wdata[4:0], 2);
    endproperty
    a_filt_cfg: assert property (p_filt_cfg) else $error("filt cfg");
    property p_bw;
        CFG_O.offset_bw <= ddsc_pkg::BW_MAX;
    endproperty
    a_bw: assert property (p_bw) else $error("bw above 13");
    property p_master;
        SYNC_O != 4'h0 |-> $past(master_q);
    endproperty
    a_master: assert property (p_master) else $error("sync no master");
    property p_tun_load;
        SYNC_O.tun_sync |-> PHASE_LOAD_O;
    endproperty
    a_tun_load: assert property (p_tun_load) else $error("no load");
    property p_force;
        (fc_q[3] && $stable(fc_q)) [*3] |-> LEVEL_FLAG_PIN_O == fc_q[2];
    endproperty
    a_force: assert property (p_force) else $error("force value");
    property p_off;
        (!fc_q[3] && !fc_q[0] && $stable(fc_q)) [*3] |-> !LEVEL_FLAG_PIN_O;
    endproperty
    a_off: assert property (p_off) else $error("flag while off");
    property p_rise;
        MAG_VALID_I && fc_q == 8'h01 && $past(fc_q) == 8'h01 && MAG_I > up_q
            |-> ##2 LEVEL_FLAG_PIN_O;
    endproperty
    a_rise: assert property (p_rise) else $error("flag not set");
    property p_fall;
        $fell(LEVEL_FLAG_PIN_O) && fc_q == 8'h01 && $past(fc_q) == 8'h01
            |-> $past(MAG_VALID_I, 2) && $past(MAG_I, 2) < $past(lo_q, 2);
    endproperty
    a_fall: assert property (p_fall) else $error("early clear");
endmodule
bind ddsc_bank ddsc_props i_ddsc_props (.*);
`default_nettype wire

// ### ddsc_host.sv
// host model: register writes and reads
// assumes requests change on the falling clock edge
`default_nettype none
module ddsc_host (
    input wire logic clk_i,
    input wire logic rvalid_i,
    input wire logic [7:0] rdata_i,
    output var ddsc_pkg::ddsc_req_type req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_o = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_o = {1'b1, 1'b0, a, d};
        @(negedge clk_i);
        req_o = '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
        @(negedge clk_i);
        req_o = {1'b0, 1'b1, a, 8'h00};
        @(negedge clk_i);
        req_o = '0;
        ok = rvalid_i;
        d = rdata_i;
    endtask
    // quarter-rate link with fixed tuning word
    task automatic fixed_qtr();
        wr(ddsc_pkg::ADDR_TW3, 8'h40);
        wr(ddsc_pkg::ADDR_TW2, 8'h00);
        wr(ddsc_pkg::ADDR_TW1, 8'h00);
        wr(ddsc_pkg::ADDR_TW0, 8'h00);
        wr(ddsc_pkg::ADDR_OSC, 8'h40);
    endtask
endmodule
`default_nettype wire

// ### ddsc_bank_test.sv
// testbench for ddsc_bank
// assumes ddsc_host as register master and the bound checker
`default_nettype none
module ddsc_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, sync_in, osc_start, mag_valid, rvalid, phase_load, pin;
    logic [12:0] mag;
    logic [7:0] rdata;
    logic [3:0] seen;
    logic [4:0] f;
    logic saw_load;
    ddsc_pkg::ddsc_req_type req;
    ddsc_pkg::ddsc_sync_type sync_o;
    ddsc_pkg::ddsc_cfg_type cfg;
    int failures, checks_done;
    ddsc_bank #(.DWELL_W(16)) i_ddsc_bank (
        .CORE_CLK_I(clk), .NRST_I(nrst), .REQ_I(req), .SYNC_I(sync_in),
        .OSC_START_I(osc_start), .MAG_I(mag), .MAG_VALID_I(mag_valid),
        .RDATA_O(rdata), .RVALID_O(rvalid), .SYNC_O(sync_o),
        .PHASE_LOAD_O(phase_load), .CFG_O(cfg), .LEVEL_FLAG_PIN_O(pin)
    );
    ddsc_host i_ddsc_host (
        .clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .req_o(req)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic ok;
        logic [7:0] d;
        i_ddsc_host.rd(a, d, ok);
        check(32'(ok), 32'h0000_0001);
        check(32'(d), 32'(e));
    endtask
    // let cfg settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_ddsc_host.wr(a, d);
        @(negedge clk);
    endtask
    task automatic sync_chk(input logic [3:0] e, input logic el);
        seen = 4'h0;
        saw_load = 1'b0;
        @(negedge clk);
        sync_in = 1'b1;
        repeat (8) begin
            @(negedge clk);
            seen = seen | sync_o;
            saw_load = saw_load | phase_load;
        end
        sync_in = 1'b0;
        repeat (3) @(negedge clk);
        check(32'(seen), 32'(e));
        check(32'(saw_load), 32'(el));
    endtask
    task automatic samp(input logic [12:0] m, input int n);
        repeat (n) begin
            @(negedge clk);
            mag = m;
            mag_valid = 1'b1;
        end
        @(negedge clk);
        mag_valid = 1'b0;
    endtask
    task automatic pin_chk(input logic e);
        repeat (3) @(negedge clk);
        check(32'(pin), 32'(e));
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        failures++;
        $display("CHECK FAILED %0t run did not finish", $time);
        end_of_test();
    end
    ////////////////////////////////////////
    initial begin
        failures = 0;
        checks_done = 0;
        nrst = 1'b0;
        sync_in = 1'b0;
        osc_start = 1'b0;
        mag = 13'h0000;
        mag_valid = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        rd_chk(ddsc_pkg::ADDR_FILT, 8'hB0);
        rd_chk(ddsc_pkg::ADDR_OSC, 8'h51);
        rd_chk(ddsc_pkg::ADDR_TW3, 8'h40);
        rd_chk(8'h30, 8'h00);
        check(cfg.tuning_word, 32'h4000_0000);
        check(32'({cfg.fir_low_latency, cfg.qtr_link}),
            32'h0000_0003);
        for (int i = 0; i < 32; i++) begin
            wr(ddsc_pkg::ADDR_FILT, 8'(i));
            f = {cfg.fir_low_latency, cfg.out_gain_6db, cfg.narrow_mode,
                cfg.dp_gain};
            check(32'(f), 32'(i));
            rd_chk(ddsc_pkg::ADDR_FILT, 8'(i) | 8'hA0);
        end
        i_ddsc_host.fixed_qtr();
        @(negedge clk);
        check(32'(cfg.qtr_link), 32'h0000_0001);
        wr(ddsc_pkg::ADDR_OSC, 8'h26);
        check(32'({cfg.reverse, cfg.amp_dither, cfg.phase_dither,
            cfg.qtr_link}), 32'h0000_000E);
        rd_chk(ddsc_pkg::ADDR_OSC, 8'h37);
        wr(ddsc_pkg::ADDR_OSC, 8'h00);
        rd_chk(ddsc_pkg::ADDR_OSC, 8'h11);
        for (int i = 0; i < 4; i++) begin
            wr(ddsc_pkg::ADDR_TW3 + 8'(i), 8'h12 + 8'(i) * 8'h22);
        end
        wr(ddsc_pkg::ADDR_PH1, 8'hAB);
        wr(ddsc_pkg::ADDR_PH0, 8'hCD);
        check(cfg.tuning_word, 32'h1234_5678);
        check(32'(cfg.phase_start_value), 32'h0000_ABCD);
        wr(ddsc_pkg::ADDR_OFFSET_CTL, 8'h7E);
        check(32'({cfg.offset_en, cfg.offset_freeze, cfg.offset_bw}),
            32'h0000_003D);
        wr(ddsc_pkg::ADDR_OFFSET_CTL, 8'h14);
        check(32'({cfg.offset_en, cfg.offset_freeze, cfg.offset_bw}),
            32'h0000_0005);
        wr(ddsc_pkg::ADDR_SYNC_GATE, 8'h02);
        wr(ddsc_pkg::ADDR_DP_SYNC, 8'h51);
        sync_chk(4'h0, 1'b0);
        wr(ddsc_pkg::ADDR_SYNC_GATE, 8'h03);
        sync_chk(4'hF, 1'b1);
        sync_chk(4'hF, 1'b1);
        rd_chk(ddsc_pkg::ADDR_SYNC_GATE, 8'h03);
        wr(ddsc_pkg::ADDR_SYNC_GATE, 8'h07);
        wr(ddsc_pkg::ADDR_DP_SYNC, 8'hF3);
        sync_chk(4'hF, 1'b1);
        rd_chk(ddsc_pkg::ADDR_SYNC_GATE, 8'h05);
        rd_chk(ddsc_pkg::ADDR_DP_SYNC, 8'hA2);
        sync_chk(4'h0, 1'b0);
        @(negedge clk);
        osc_start = 1'b1;
        @(negedge clk);
        osc_start = 1'b0;
        check(32'(phase_load), 32'h0000_0001);
        wr(ddsc_pkg::ADDR_SYNC_GATE, 8'h00);
        wr(ddsc_pkg::ADDR_UP_HI, 8'h10);
        wr(ddsc_pkg::ADDR_LO_LO, 8'h32);
        wr(ddsc_pkg::ADDR_HOLD_LO, 8'h03);
        wr(ddsc_pkg::ADDR_FLAG_CTL, 8'h01);
        samp(13'h1000, 2);
        pin_chk(1'b0);
        samp(13'h1001, 1);
        pin_chk(1'b1);
        samp(13'h000A, 2);
        samp(13'h0046, 1);
        samp(13'h000A, 2);
        pin_chk(1'b1);
        samp(13'h000A, 1);
        pin_chk(1'b0);
        wr(ddsc_pkg::ADDR_HOLD_LO, 8'h00);
        wr(ddsc_pkg::ADDR_HOLD_HI, 8'h01);
        samp(13'h1388, 1);
        samp(13'h000A, 255);
        pin_chk(1'b1);
        samp(13'h000A, 1);
        pin_chk(1'b0);
        wr(ddsc_pkg::ADDR_FLAG_CTL, 8'h0D);
        pin_chk(1'b1);
        wr(ddsc_pkg::ADDR_FLAG_CTL, 8'h09);
        pin_chk(1'b0);
        wr(ddsc_pkg::ADDR_FLAG_CTL, 8'h00);
        samp(13'h1388, 1);
        pin_chk(1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
